/* File: src/lemsc_pkg.sv */
// constants for the loop to e&m signaling converter
package lemsc_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   // m lead ringing modulation, half period of 20 hz
   localparam int unsigned RING_MOD_HZ = 20;
   localparam int unsigned RING_HALF_CYC = CLK_HZ / (2 * RING_MOD_HZ);
   // wink length in milliseconds
   localparam int unsigned WINK_MS = 150;
   localparam int unsigned WINK_CYC = (CLK_HZ / 1000) * WINK_MS;
   // traffic monitor release delay, above longest dial break (ms)
   localparam int unsigned MON_HOLD_MS = 300;
   localparam int unsigned MON_HOLD_CYC = (CLK_HZ / 1000) * MON_HOLD_MS;
   // pulse corrector: output break fraction in per mille
   localparam int unsigned PC_BREAK_PM = 580;
   localparam int unsigned PC_14PPS_BREAK_PM = 570;
   // dial period boundary: above 1/13 s counts as 8-12 pps
   localparam int unsigned PC_SLOW_MS = 77;
   localparam int unsigned PC_SLOW_CYC = (CLK_HZ / 1000) * PC_SLOW_MS;
   // longest dial period accepted (8 pps = 125 ms), with margin
   localparam int unsigned PC_MAX_MS = 130;
   localparam int unsigned PC_MAX_CYC = (CLK_HZ / 1000) * PC_MAX_MS;
   // default period before any pulse measured (10 pps)
   localparam int unsigned PC_DEF_MS = 100;
   localparam int unsigned PC_DEF_CYC = (CLK_HZ / 1000) * PC_DEF_MS;
   localparam int unsigned CNT_W = 27;
   typedef logic [CNT_W-1:0] lemsc_cnt_t;
   // m lead level encoding on the output
   localparam logic M_GND = 1'b0;
   localparam logic M_BATT = 1'b1;
   typedef enum logic [2:0] {
      GS_IDLE,
      GS_SEIZED,
      GS_ACTIVE,
      GS_RINGING,
      GS_FWD_DISC
   } lemsc_gs_e;
endpackage

/* File: src/lemsc_top.sv */
// loop to e&m signaling converter, supervisory state logic
`timescale 1ns/1ps
// Operation
// - loop start: e open is idle, e ground is seizure, m at battery except ground during ringing with e open.
// - ground start: m at ground when idle or released, battery once tip is grounded, through dialing and answer.
// - ground start ringing in tone mode toggles m between ground and battery at 20 hz.
// - on forward disconnect the facility holds e after the far end opens tip, while m returns to ground.
// - in dc mode transient suppression is applied while the monitor holds and the loop is open, idle termination while the monitor is released.
// - with wink selected in ground start dc mode a brief m wink precedes ringing.
// - pulse correction regenerates 8 to 12 pps dial pulses to a 58 percent break.
// - pulse correction regenerates 14 pps dial pulses to a 57 percent break.
// - without correction dial pulses pass with under 5 percent added break distortion.
// - traffic monitor is asserted while e is grounded and holds through dial breaks.
// - inverted polarity in dc mode swaps the m lead potentials.
module lemsc_top
   import lemsc_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic arst_n,
   // configuration
   input  wire logic ground_start_select,
   input  wire logic dc_mode_select,
   input  wire logic m_polarity_normal,
   input  wire logic wink_enable,
   input  wire logic pulse_correct_enable,
   // facility side
   input  wire logic e_lead_gnd,
   output logic      m_lead_batt,
   // switching side
   input  wire logic ringing_detect,
   input  wire logic tip_gnd_detect,
   output logic      loop_closed,
   // dc facility helpers and monitor
   output logic      transient_suppress,
   output logic      idle_terminate,
   output logic      traffic_monitor_out
);

   //------------------------------------------------------------
   // mode decode
   //------------------------------------------------------------
   wire loop_start_select = ~ground_start_select;
   wire invert_m = dc_mode_select & ~m_polarity_normal;
   wire wink_ok  = wink_enable & dc_mode_select & ground_start_select;

   //------------------------------------------------------------
   // 20 hz modulation enable
   //------------------------------------------------------------
   lemsc_cnt_t mod_cnt_q;
   logic       mod_ph_q;
   wire        mod_tick = (mod_cnt_q == lemsc_cnt_t'(RING_HALF_CYC - 1));
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mod_cnt_q <= '0;
         mod_ph_q  <= 1'b0;
      end else if (mod_tick) begin
         mod_cnt_q <= '0;
         mod_ph_q  <= ~mod_ph_q;
      end else begin
         mod_cnt_q <= mod_cnt_q + lemsc_cnt_t'(1);
      end
   end

   //------------------------------------------------------------
   // ground start state machine
   //------------------------------------------------------------
   lemsc_gs_e gs_q;
   lemsc_gs_e gs_d;
   always_comb begin
      gs_d = gs_q;
      unique case (gs_q)
         GS_IDLE: begin
            if (tip_gnd_detect)
               gs_d = ringing_detect ? GS_RINGING : GS_ACTIVE;
            else if (e_lead_gnd)
               gs_d = GS_SEIZED;
         end
         GS_SEIZED: begin
            if (tip_gnd_detect)
               gs_d = GS_ACTIVE;
            else if (!e_lead_gnd)
               gs_d = GS_IDLE;
         end
         GS_ACTIVE: begin
            if (!tip_gnd_detect)
               gs_d = e_lead_gnd ? GS_FWD_DISC : GS_IDLE;
            else if (ringing_detect && !e_lead_gnd)
               gs_d = GS_RINGING;
         end
         GS_RINGING: begin
            if (!tip_gnd_detect)
               gs_d = GS_IDLE;
            else if (!ringing_detect)
               gs_d = GS_ACTIVE;
         end
         GS_FWD_DISC: begin
            if (!e_lead_gnd)
               gs_d = GS_IDLE;
            else if (tip_gnd_detect)
               gs_d = GS_ACTIVE;
         end
      endcase
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         gs_q <= GS_IDLE;
      else if (loop_start_select)
         gs_q <= GS_IDLE;
      else
         gs_q <= gs_d;
   end

   //------------------------------------------------------------
   // wink before ringing
   //------------------------------------------------------------
   lemsc_cnt_t wink_cnt_q;
   logic       ring_prev_q;
   wire        ring_start = (gs_q == GS_RINGING) & ~ring_prev_q;
   wire        winking    = (wink_cnt_q != '0);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wink_cnt_q  <= '0;
         ring_prev_q <= 1'b0;
      end else begin
         ring_prev_q <= (gs_q == GS_RINGING);
         if (ring_start && wink_ok)
            wink_cnt_q <= lemsc_cnt_t'(WINK_CYC);
         else if (winking)
            wink_cnt_q <= wink_cnt_q - lemsc_cnt_t'(1);
      end
   end

   //------------------------------------------------------------
   // m lead level before polarity
   //------------------------------------------------------------
   logic m_m_polarity_normal;
   always_comb begin
      if (loop_start_select) begin
         m_m_polarity_normal = (ringing_detect && !e_lead_gnd) ? M_GND : M_BATT;
      end else begin
         unique case (gs_q)
            GS_IDLE, GS_SEIZED: m_m_polarity_normal = M_GND;
            // m back to ground on disconnect
            GS_FWD_DISC:        m_m_polarity_normal = M_GND;
            GS_RINGING: begin
               if (!dc_mode_select)
                  m_m_polarity_normal = mod_ph_q ? M_BATT : M_GND;
               else if (winking)
                  m_m_polarity_normal = M_GND;
               else
                  m_m_polarity_normal = M_BATT;
            end
            default:            m_m_polarity_normal = M_BATT;
         endcase
      end
   end

   wire m_next = m_m_polarity_normal ^ invert_m;

   //------------------------------------------------------------
   // dial pulse path and pulse correction
   //------------------------------------------------------------
   lemsc_cnt_t per_q;
   lemsc_cnt_t per_cnt_q;
   lemsc_cnt_t brk_cnt_q;
   logic       e_prev_q;
   logic       pc_brk_q;
   wire        e_fall = e_prev_q & ~e_lead_gnd;
   wire        slow   = (per_q > lemsc_cnt_t'(PC_SLOW_CYC));
   wire [35:0] brk_prod = {9'h000, per_q} *
                          36'(slow ? PC_BREAK_PM : PC_14PPS_BREAK_PM);
   wire lemsc_cnt_t brk_len = lemsc_cnt_t'(brk_prod / 36'd1000);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         e_prev_q  <= 1'b0;
         per_q     <= lemsc_cnt_t'(PC_DEF_CYC);
         per_cnt_q <= '0;
         brk_cnt_q <= '0;
         pc_brk_q  <= 1'b0;
      end else begin
         e_prev_q <= e_lead_gnd;
         // measure break-to-break period
         if (e_fall) begin
            per_cnt_q <= '0;
            if (per_cnt_q < lemsc_cnt_t'(PC_MAX_CYC))
               per_q <= per_cnt_q;
         end else if (per_cnt_q != lemsc_cnt_t'(PC_MAX_CYC)) begin
            per_cnt_q <= per_cnt_q + lemsc_cnt_t'(1);
         end
         if (e_fall && !pc_brk_q) begin
            pc_brk_q  <= 1'b1;
            brk_cnt_q <= brk_len;
         end else if (pc_brk_q) begin
            if (brk_cnt_q <= lemsc_cnt_t'(1) && e_lead_gnd)
               pc_brk_q <= 1'b0;
            else if (brk_cnt_q != '0)
               brk_cnt_q <= brk_cnt_q - lemsc_cnt_t'(1);
         end
      end
   end

   // direct path, one cycle of skew
   wire loop_next = pulse_correct_enable ? ~pc_brk_q & e_lead_gnd
                                         : e_lead_gnd;

   //------------------------------------------------------------
   // traffic monitor hold
   //------------------------------------------------------------
   lemsc_cnt_t mon_cnt_q;
   logic       mon_q;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mon_cnt_q <= '0;
         mon_q     <= 1'b0;
      end else if (e_lead_gnd) begin
         mon_q     <= 1'b1;
         mon_cnt_q <= lemsc_cnt_t'(MON_HOLD_CYC);
      end else if (mon_cnt_q != '0) begin
         mon_cnt_q <= mon_cnt_q - lemsc_cnt_t'(1);
         if (mon_cnt_q == lemsc_cnt_t'(1))
            mon_q <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // output registers
   //------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         m_lead_batt        <= M_BATT;
         loop_closed        <= 1'b0;
         transient_suppress <= 1'b0;
         idle_terminate     <= 1'b0;
      end else begin
         m_lead_batt        <= m_next;
         loop_closed        <= loop_next;
         transient_suppress <= dc_mode_select & mon_q & ~loop_next;
         idle_terminate     <= dc_mode_select & ~mon_q;
      end
   end
   assign traffic_monitor_out = mon_q;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   AST_LS_IDLE_BATT: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (loop_start_select && !ringing_detect && !invert_m)
         |=> m_lead_batt == M_BATT)
      else $error("loop start idle m not battery");
   AST_GS_IDLE_GND: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (ground_start_select && gs_q == GS_IDLE && !invert_m)
         |=> m_lead_batt == M_GND)
      else $error("ground start idle m not ground");
   AST_RING_TOGGLE: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (gs_q == GS_RINGING && !dc_mode_select)
         |=> m_lead_batt == $past(mod_ph_q))
      else $error("ringing modulation wrong");
   AST_FWD_DISC_GND: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (gs_q == GS_FWD_DISC && !invert_m) |=> m_lead_batt == M_GND)
      else $error("forward disconnect m not ground");
   AST_DC_TERM: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (dc_mode_select && !mon_q) |=> idle_terminate)
      else $error("idle termination missing");
   AST_WINK: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (ring_start && wink_ok) |=> winking [*2])
      else $error("wink not issued");
   AST_PC_BREAK: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (e_fall && !pc_brk_q) |=> pc_brk_q && brk_cnt_q == $past(brk_len))
      else $error("corrected break not started");
   AST_DIRECT: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !pulse_correct_enable |=> loop_closed == $past(e_lead_gnd))
      else $error("direct dial path skewed");
   AST_MON_HOLD: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      $fell(e_lead_gnd) |-> traffic_monitor_out [*8])
      else $error("monitor followed dial break");
   AST_INVERT: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (invert_m && loop_start_select && !ringing_detect)
         |=> m_lead_batt == M_GND)
      else $error("m polarity swap wrong");
   AST_INVERT_GS: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (invert_m && ground_start_select && gs_q == GS_IDLE)
         |=> m_lead_batt == M_BATT)
      else $error("inverted ground start idle not battery");

endmodule

/* File: tb/lemsc_fac_model.sv */
// facility side model: drives the e lead, watches the m lead
`timescale 1ns/1ps
module lemsc_fac_model #(
   parameter int unsigned DISC_DLY = 20
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic arst_n,
   // configuration seen by the far end
   input  wire logic gs_mode,
   input  wire logic m_idle,
   // bench request and e&m leads
   input  wire logic off_hook_req,
   input  wire logic m_lead_batt,
   output logic      e_lead_gnd
);
   logic       m_prev_q;
   logic       released_q;
   logic [7:0] hold_q;
   wire logic  fwd_disc = gs_mode && off_hook_req && !released_q
                          && hold_q == 8'h00 && m_prev_q != m_idle
                          && m_lead_batt == m_idle;
   // hold e for DISC_DLY cycles once m returns to its idle level
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         m_prev_q   <= 1'b0;
         released_q <= 1'b0;
         hold_q     <= 8'h00;
      end else begin
         m_prev_q <= m_lead_batt;
         if (fwd_disc) hold_q <= DISC_DLY[7:0];
         else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
         if (!off_hook_req) released_q <= 1'b0;
         else if (hold_q == 8'h01) released_q <= 1'b1;
      end
   end
   // e ground means seizure, open means idle
   assign e_lead_gnd = off_hook_req && !released_q;
endmodule

/* File: tb/lemsc_top_tb.sv */
// self-checking bench for the signaling converter
`timescale 1ns/1ps
module lemsc_top_tb;
   import lemsc_pkg::*;
   typedef struct packed {logic [5:0] mask; logic [5:0] val;} lemsc_note_s;
   localparam int unsigned DISC_DLY = 20;
   localparam logic [5:0] EL = 6'h20, ML = 6'h10, LC = 6'h08;
   localparam logic [5:0] TS = 6'h04, IT = 6'h02, MO = 6'h01;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        ground_start_select = 1'b0;
   logic        dc_mode_select = 1'b0;
   logic        m_polarity_normal = 1'b1;
   logic        wink_enable = 1'b0;
   logic        pulse_correct_enable = 1'b0;
   logic        off_hook_req = 1'b0;
   logic        ringing_detect = 1'b0;
   logic        tip_gnd_detect = 1'b0;
   wire logic   e_lead_gnd, m_lead_batt, loop_closed;
   wire logic   transient_suppress, idle_terminate, traffic_monitor_out;
   wire logic   m_idle = ~(ground_start_select
                           ^ (dc_mode_select & ~m_polarity_normal));
   wire logic [5:0] obs = {e_lead_gnd, m_lead_batt, loop_closed,
                           transient_suppress, idle_terminate,
                           traffic_monitor_out};
   lemsc_note_s notes[$];
   lemsc_note_s note;
   event        chk_ev;
   event        chk_done;
   int          err_total = 0;
   int          checked = 0;
   int          n;

   always #2 sys_clk = ~sys_clk;

   lemsc_top uut (.sys_clk(sys_clk), .arst_n(arst_n),
      .ground_start_select(ground_start_select),
      .dc_mode_select(dc_mode_select),
      .m_polarity_normal(m_polarity_normal), .wink_enable(wink_enable),
      .pulse_correct_enable(pulse_correct_enable),
      .e_lead_gnd(e_lead_gnd),
      .m_lead_batt(m_lead_batt), .ringing_detect(ringing_detect),
      .tip_gnd_detect(tip_gnd_detect), .loop_closed(loop_closed),
      .transient_suppress(transient_suppress),
      .idle_terminate(idle_terminate),
      .traffic_monitor_out(traffic_monitor_out));

   lemsc_fac_model #(.DISC_DLY(DISC_DLY)) far_end (.sys_clk(sys_clk),
      .arst_n(arst_n), .gs_mode(ground_start_select), .m_idle(m_idle),
      .off_hook_req(off_hook_req), .m_lead_batt(m_lead_batt),
      .e_lead_gnd(e_lead_gnd));

   task automatic step(input int cyc);
      repeat (cyc) @(posedge sys_clk);
      #1;
   endtask

   task automatic check_eq(input logic [5:0] seen, input logic [5:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t outputs %b expected %b", $time, seen, exp);
      end
   endtask

   task automatic expect_out(input logic [5:0] mask, input logic [5:0] val);
      notes.push_back('{mask, val});
      -> chk_ev;
      // hold stimulus until the monitor has compared
      @(chk_done);
   endtask

   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic do_reset(input int cyc, input logic gs, input logic dc,
                           input logic pol, input logic wk);
      arst_n = 1'b0;
      {ground_start_select, dc_mode_select} = {gs, dc};
      {m_polarity_normal, wink_enable} = {pol, wk};
      {off_hook_req, ringing_detect, tip_gnd_detect} = 3'b000;
      step(cyc);
      expect_out(6'h3f, ML);
      arst_n = 1'b1;
      step(3);
   endtask

   // ---------------------------------------------------------------
   // result monitor
   // ---------------------------------------------------------------
   always @(chk_ev) begin
      while (notes.size() > 0) begin
         note = notes.pop_front();
         check_eq(obs & note.mask, note.val & note.mask);
      end
      -> chk_done;
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h8c297427));
      do_reset(10, 1'b0, 1'b0, 1'b1, 1'b0);
      expect_out(ML | LC | TS | IT | MO, ML);
      ringing_detect = 1'b1;
      step(2);
      expect_out(ML | LC, 6'h00);
      ringing_detect = 1'b0;
      off_hook_req = 1'b1;
      step(3);
      expect_out(EL | ML | LC | MO, EL | ML | LC | MO);
      off_hook_req = 1'b0;
      step(3);
      expect_out(LC | TS | MO, MO);
      do_reset(2, 1'b0, 1'b1, 1'b1, 1'b0);
      expect_out(ML | IT | MO, ML | IT);
      off_hook_req = 1'b1;
      step(3);
      expect_out(LC | IT | MO, LC | MO);
      for (int i = 0; i < 4; i++) begin
         n = 3 + int'($urandom % 8);
         off_hook_req = 1'b0;
         step(2);
         expect_out(LC | TS | MO, TS | MO);
         step(n);
         expect_out(LC | MO, MO);
         off_hook_req = 1'b1;
         step(2);
         expect_out(LC | MO, LC | MO);
      end
      do_reset(2, 1'b0, 1'b0, 1'b0, 1'b0);
      expect_out(ML, ML);
      pulse_correct_enable = 1'b1;
      off_hook_req = 1'b1;
      step(3);
      expect_out(LC, LC);
      off_hook_req = 1'b0;
      step(2);
      off_hook_req = 1'b1;
      step(3);
      expect_out(LC, 6'h00);
      pulse_correct_enable = 1'b0;
      do_reset(2, 1'b0, 1'b1, 1'b0, 1'b0);
      expect_out(ML, 6'h00);
      ringing_detect = 1'b1;
      step(2);
      expect_out(ML, ML);
      do_reset(2, 1'b1, 1'b1, 1'b1, 1'b0);
      expect_out(ML | IT, IT);
      off_hook_req = 1'b1;
      step(3);
      expect_out(ML | LC | MO, LC | MO);
      tip_gnd_detect = 1'b1;
      step(3);
      expect_out(ML, ML);
      tip_gnd_detect = 1'b0;
      step(3);
      expect_out(EL | ML, EL);
      step(DISC_DLY + 4);
      expect_out(EL | ML | LC, 6'h00);
      do_reset(2, 1'b1, 1'b1, 1'b0, 1'b0);
      expect_out(ML, ML);
      off_hook_req = 1'b1;
      tip_gnd_detect = 1'b1;
      step(4);
      expect_out(ML, 6'h00);
      do_reset(2, 1'b1, 1'b0, 1'b1, 1'b0);
      tip_gnd_detect = 1'b1;
      step(3);
      expect_out(ML, ML);
      ringing_detect = 1'b1;
      step(3);
      expect_out(ML, 6'h00);
      step(1000);
      expect_out(ML, 6'h00);
      for (int w = 0; w < 2; w++) begin
         do_reset(2, 1'b1, 1'b1, 1'b1, w[0]);
         tip_gnd_detect = 1'b1;
         step(3);
         ringing_detect = 1'b1;
         step(3);
         expect_out(ML, w[0] ? 6'h00 : ML);
      end
      print_verdict();
   end

   // watchdog against a hang
   initial begin
      #40000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule
